// ==== design/hbe_unit.sv ====
// Behaviour
// - Store-value write failure reports host-write-failure code.
// - Packet load waits until store-value write finishes.
// - Async receive write error halts, fatal, no irq.
// - Pointer keeps failing descriptor; input FIFO flushed.
// - Packet-per-buffer error sets code, discards packet rest.
// - Buffer-fill overrun backs packet out, discards rest.
// - Buffer-fill host error halts, fatal, pointer, flush.
// - First physical read failure answers resp_data_error.
// - Later physical read failure truncates the response.
// - Busy/data-error ack retries; host error retries resp_data_error.
// - Failed posted write sets flag, stays pending.
// - One report entry per outstanding posted write.
// - Queue full means no posting; ack pending.
// - Flag clear consumes report; next may follow.
// - Upper word source plus offset high; lower rest.
// - Failure queues report, raises flag, drops packet.
// - Queue advances as soon as flag clears.
// - Posting resumes after success or software retirement.
// - Flag repeats per head; silent once queue empty.
// - Without posting support never acknowledge as posted.
`timescale 1ns/10ps
module hbe_unit #(
	parameter int unsigned PW_DEPTH   = hbe_pkg::PW_DEPTH_DEF,
	parameter bit          PW_SUPPORT = 1'b1
)(
	input  logic                                    sys_clk,
	input  logic                                    reset,
	input  logic                                    it_store_req,
	input  logic                                    it_store_done,
	input  logic                                    it_store_err,
	input  logic                                    it_pkt_ready,
	output logic                                    it_fifo_load,
	output logic                                    it_abort,
	output logic [hbe_pkg::EVT_W-1:0]               it_event_code,
	input  logic [hbe_pkg::MODE_W-1:0]              ir_mode,
	input  logic [hbe_pkg::RX_N-1:0]                rx_host_err,
	input  logic [hbe_pkg::RX_N-1:0]                rx_overrun,
	input  logic [hbe_pkg::RX_N-1:0]                rx_pkt_end,
	input  logic [hbe_pkg::RX_N-1:0]                rx_xfer_done,
	input  logic [hbe_pkg::RX_N-1:0]                rx_desc_irq,
	input  logic [hbe_pkg::RX_N-1:0]                rx_resume,
	input  logic [hbe_pkg::RX_N-1:0][hbe_pkg::WORD_W-1:0] current_desc_addr,
	output logic [hbe_pkg::RX_N-1:0]                context_halted_flag,
	output logic [hbe_pkg::RX_N-1:0][hbe_pkg::EVT_W-1:0]  context_event_code,
	output logic [hbe_pkg::RX_N-1:0][hbe_pkg::WORD_W-1:0] descriptor_list_pointer,
	output logic [hbe_pkg::RX_N-1:0]                rx_flush_all,
	output logic [hbe_pkg::RX_N-1:0]                rx_discard_pkt,
	output logic [hbe_pkg::RX_N-1:0]                rx_backout,
	output logic [hbe_pkg::RX_N-1:0]                rx_status_upd,
	output logic [hbe_pkg::RX_N-1:0]                rx_ctx_irq,
	output logic                                    fatal_error_flag,
	input  logic                                    pr_start,
	input  logic                                    pr_rd_err,
	input  logic                                    pr_underrun,
	input  logic                                    pr_word_sent,
	input  logic                                    pr_pkt_end,
	input  logic                                    pr_ack_valid,
	input  logic [hbe_pkg::CODE_W-1:0]              pr_ack_code,
	input  logic [3:0]                              pr_max_retries,
	output logic [hbe_pkg::CODE_W-1:0]              pr_resp_code,
	output logic                                    pr_stop,
	output logic                                    pr_retry,
	output logic                                    pr_busy,
	input  logic                                    pw_enable,
	input  logic                                    pw_req,
	input  logic [hbe_pkg::SRC_W-1:0]               requester_node_ident,
	input  logic [hbe_pkg::OFF_W-1:0]               pw_dest_offset,
	input  logic                                    pw_wr_done,
	input  logic                                    pw_wr_fail,
	input  logic                                    pw_flag_clr,
	output logic                                    pw_ack_valid,
	output logic [hbe_pkg::CODE_W-1:0]              pw_ack_code,
	output logic                                    pw_drop_pkt,
	output logic                                    posted_fail_flag,
	output logic [hbe_pkg::WORD_W-1:0]              posted_fail_source_and_offset_upper,
	output logic [hbe_pkg::WORD_W-1:0]              posted_fail_offset_lower
);
	import hbe_pkg::*;

	localparam int unsigned CW = $clog2(PW_DEPTH + 1);

	typedef struct packed {
		logic              it_busy;
		logic              it_abort;
		logic [EVT_W-1:0]  it_evt;
		hbe_pr_state_e     pr_st;
		logic              pr_sent;
		logic              pr_hbe;
		logic              pr_stop;
		logic [CODE_W-1:0] pr_resp;
		logic [3:0]        pr_tries;
		logic              pr_retry;
		logic              pw_ack_v;
		logic [CODE_W-1:0] pw_ack;
		logic              pw_drop;
		logic              pw_flag;
		logic [WORD_W-1:0] rpt_hi;
		logic [WORD_W-1:0] rpt_lo;
	} hbe_top_s;

	hbe_top_s             st_r;
	hbe_top_s             st_nxt;
	logic [RX_N-1:0]      rx_fatal;
	logic [RPT_W-1:0]     fly_head;
	logic [RPT_W-1:0]     fail_head;
	logic [CW-1:0]        fly_cnt;
	logic [CW-1:0]        fail_cnt;
	logic                 fail_empty;
	logic [CW:0]          pw_total;
	logic                 pw_post;
	logic                 fail_pop;

	// =====================================================
	// Receive contexts: 0 is asynchronous, 1 isochronous
	for (genvar g = 0; g < RX_N; g++)
	begin : g_rx
		hbe_rxerr u_rx (
			.sys_clk           (sys_clk),
			.reset             (reset),
			.mode              ((g == 0) ? MODE_ASYNC : ir_mode),
			.host_err          (rx_host_err[g]),
			.overrun           (rx_overrun[g]),
			.pkt_end           (rx_pkt_end[g]),
			.xfer_done         (rx_xfer_done[g]),
			.desc_irq          (rx_desc_irq[g]),
			.resume            (rx_resume[g]),
			.current_desc_addr (current_desc_addr[g]),
			.halted            (context_halted_flag[g]),
			.event_code        (context_event_code[g]),
			.desc_ptr          (descriptor_list_pointer[g]),
			.flush_all         (rx_flush_all[g]),
			.discard_pkt       (rx_discard_pkt[g]),
			.backout           (rx_backout[g]),
			.status_upd        (rx_status_upd[g]),
			.fatal             (rx_fatal[g]),
			.ctx_irq           (rx_ctx_irq[g])
		);
	end

	assign fatal_error_flag = |rx_fatal;

	// =====================================================
	// Posted write queues: in flight and failed
	hbe_fifo #(.DEPTH(PW_DEPTH), .WIDTH(RPT_W)) u_fly (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.push      (pw_post),
		.push_data ({requester_node_ident, pw_dest_offset}),
		.pop       (pw_wr_done || pw_wr_fail),
		.head      (fly_head),
		.count     (fly_cnt),
		.empty     (),
		.full      ()
	);

	hbe_fifo #(.DEPTH(PW_DEPTH), .WIDTH(RPT_W)) u_fail (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.push      (pw_wr_fail),
		.push_data (fly_head),
		.pop       (fail_pop),
		.head      (fail_head),
		.count     (fail_cnt),
		.empty     (fail_empty),
		.full      ()
	);

	// A failed write keeps its slot until software retires it
	assign pw_total = {1'b0, fly_cnt} + {1'b0, fail_cnt};
	assign pw_post  = PW_SUPPORT && pw_enable && pw_req && (pw_total < (CW+1)'(PW_DEPTH));
	assign fail_pop = pw_flag_clr && st_r.pw_flag;

	// Handshake output: packet may be loaded once no store-value is open
	assign it_fifo_load = it_pkt_ready && !st_r.it_busy && !it_store_req;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.it_abort = 1'b0;
		st_nxt.pr_retry = 1'b0;
		st_nxt.pw_ack_v = 1'b0;
		st_nxt.pw_drop = 1'b0;

		// =====================================================
		// Isochronous transmit store-value write
		if (it_store_req)
			st_nxt.it_busy = 1'b1;
		else if (it_store_done || it_store_err)
			st_nxt.it_busy = 1'b0;
		if (it_store_err)
		begin
			st_nxt.it_evt = EVT_DATA_WRITE;
			st_nxt.it_abort = 1'b1;
		end
		else if (it_store_done)
			st_nxt.it_evt = EVT_NONE;

		// =====================================================
		// Physical read response
		case (st_r.pr_st)
			PR_IDLE:
			begin
				if (pr_start)
				begin
					st_nxt.pr_st = PR_SEND;
					st_nxt.pr_sent = 1'b0;
					st_nxt.pr_hbe = 1'b0;
					st_nxt.pr_stop = 1'b0;
					st_nxt.pr_resp = RESP_COMPLETE;
					st_nxt.pr_tries = '0;
				end
			end
			PR_SEND:
			begin
				if (pr_rd_err && !st_r.pr_stop)
				begin
					st_nxt.pr_hbe = 1'b1;
					st_nxt.pr_stop = 1'b1;
					if (!st_r.pr_sent)
						st_nxt.pr_resp = RESP_DATA_ERR;
				end
				else if (pr_underrun && st_r.pr_sent)
					st_nxt.pr_stop = 1'b1;
				if (pr_word_sent)
					st_nxt.pr_sent = 1'b1;
				if (pr_pkt_end)
					st_nxt.pr_st = PR_ACK;
			end
			PR_ACK:
			begin
				if (pr_ack_valid)
				begin
					if ((pr_ack_code == ACK_BUSY || pr_ack_code == ACK_DATA_ERR)
						&& st_r.pr_tries != pr_max_retries)
					begin
						st_nxt.pr_st = PR_SEND;
						st_nxt.pr_retry = 1'b1;
						st_nxt.pr_tries = st_r.pr_tries + 4'h1;
						st_nxt.pr_sent = 1'b0;
						st_nxt.pr_stop = st_r.pr_hbe;
						if (st_r.pr_hbe)
							st_nxt.pr_resp = RESP_DATA_ERR;
					end
					else
						st_nxt.pr_st = PR_IDLE;
				end
			end
			default:
				st_nxt.pr_st = PR_IDLE;
		endcase

		// =====================================================
		// Posted write acknowledge and failure report
		if (pw_req)
		begin
			st_nxt.pw_ack_v = 1'b1;
			st_nxt.pw_ack = pw_post ? ACK_COMPLETE : ACK_PENDING;
		end
		if (pw_wr_fail)
			st_nxt.pw_drop = 1'b1;
		// Clearing drops the flag for at least one cycle so software sees the edge
		if (st_r.pw_flag && pw_flag_clr)
			st_nxt.pw_flag = 1'b0;
		else if (!st_r.pw_flag && !fail_empty)
		begin
			st_nxt.pw_flag = 1'b1;
			st_nxt.rpt_hi = fail_head[RPT_W-1:WORD_W];
			st_nxt.rpt_lo = fail_head[WORD_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
			st_r <= '{it_evt: EVT_NONE, pr_st: PR_IDLE, pr_resp: RESP_COMPLETE,
				pw_ack: ACK_PENDING, rpt_hi: RPT_RST, rpt_lo: RPT_RST, default: '0};
		else
			st_r <= st_nxt;

	assign it_abort      = st_r.it_abort;
	assign it_event_code = st_r.it_evt;
	assign pr_resp_code  = st_r.pr_resp;
	assign pr_stop       = st_r.pr_stop;
	assign pr_retry      = st_r.pr_retry;
	assign pr_busy       = (st_r.pr_st != PR_IDLE);
	assign pw_ack_valid  = st_r.pw_ack_v;
	assign pw_ack_code   = st_r.pw_ack;
	assign pw_drop_pkt   = st_r.pw_drop;
	assign posted_fail_flag = st_r.pw_flag;
	assign posted_fail_source_and_offset_upper = st_r.rpt_hi;
	assign posted_fail_offset_lower = st_r.rpt_lo;

	// =====================================================
	// Checks
	property p_it_code;
		@(posedge sys_clk) disable iff (reset)
		it_store_err |=> it_event_code == EVT_DATA_WRITE && it_abort;
	endproperty
	a_it_code: assert property (p_it_code) else $error("store error not reported");

	property p_it_gate;
		@(posedge sys_clk) disable iff (reset)
		it_store_req ##1 (!it_store_done && !it_store_err)[*2] |-> !it_fifo_load;
	endproperty
	a_it_gate: assert property (p_it_gate) else $error("load before store done");

	property p_pr_first;
		@(posedge sys_clk) disable iff (reset)
		st_r.pr_st == PR_SEND && pr_rd_err && !st_r.pr_sent && !st_r.pr_stop
		|=> pr_resp_code == RESP_DATA_ERR && pr_stop;
	endproperty
	a_pr_first: assert property (p_pr_first) else $error("no data error response");

	property p_pr_trunc;
		@(posedge sys_clk) disable iff (reset)
		st_r.pr_st == PR_SEND && pr_rd_err && st_r.pr_sent
		|=> pr_stop && pr_resp_code == $past(pr_resp_code);
	endproperty
	a_pr_trunc: assert property (p_pr_trunc) else $error("response not truncated");

	property p_pr_retry;
		@(posedge sys_clk) disable iff (reset)
		pr_retry && st_r.pr_hbe |-> pr_resp_code == RESP_DATA_ERR && pr_busy;
	endproperty
	a_pr_retry: assert property (p_pr_retry) else $error("retry kept data");

	property p_pw_limit;
		@(posedge sys_clk) disable iff (reset)
		pw_req && pw_total >= (CW+1)'(PW_DEPTH) |=> pw_ack_code == ACK_PENDING;
	endproperty
	a_pw_limit: assert property (p_pw_limit) else $error("posted beyond depth");

	property p_pw_none;
		@(posedge sys_clk) disable iff (reset)
		pw_req && !(PW_SUPPORT && pw_enable) |=> pw_ack_valid && pw_ack_code != ACK_COMPLETE;
	endproperty
	a_pw_none: assert property (p_pw_none) else $error("posted without support");

	property p_pw_flag;
		@(posedge sys_clk) disable iff (reset)
		posted_fail_flag && pw_flag_clr |=> !posted_fail_flag;
	endproperty
	a_pw_flag: assert property (p_pw_flag) else $error("flag set in clear cycle");

	property p_pw_report;
		@(posedge sys_clk) disable iff (reset)
		!posted_fail_flag && !fail_empty && !pw_flag_clr
		|=> posted_fail_flag && {posted_fail_source_and_offset_upper,
			posted_fail_offset_lower} == $past(fail_head);
	endproperty
	a_pw_report: assert property (p_pw_report) else $error("report not presented");

	property p_pw_empty;
		@(posedge sys_clk) disable iff (reset)
		posted_fail_flag |-> !fail_empty;
	endproperty
	a_pw_empty: assert property (p_pw_empty) else $error("flag with empty queue");

	c_pw_fail: cover property (@(posedge sys_clk) disable iff (reset) $rose(posted_fail_flag));
	c_pr_retry: cover property (@(posedge sys_clk) disable iff (reset) pr_retry && st_r.pr_hbe);
	c_rx_halt: cover property (@(posedge sys_clk) disable iff (reset) fatal_error_flag);
endmodule

// ==== design/hbe_pkg.sv ====
package hbe_pkg;
	// =====================================================
	// Widths
	localparam int unsigned EVT_W    = 5;
	localparam int unsigned CODE_W   = 4;
	localparam int unsigned SRC_W    = 16;
	localparam int unsigned OFF_W    = 48;
	localparam int unsigned RPT_W    = SRC_W + OFF_W;
	localparam int unsigned WORD_W   = 32;
	localparam int unsigned MODE_W   = 2;
	localparam int unsigned RX_N     = 2;
	localparam int unsigned PW_DEPTH_DEF = 3;

	// =====================================================
	// Context event codes
	localparam logic [EVT_W-1:0] EVT_NONE       = 5'h00;
	localparam logic [EVT_W-1:0] EVT_DATA_WRITE = 5'h01;
	localparam logic [EVT_W-1:0] EVT_OVERRUN    = 5'h02;

	// =====================================================
	// Serial bus ack and response codes
	localparam logic [CODE_W-1:0] ACK_COMPLETE  = 4'h1;
	localparam logic [CODE_W-1:0] ACK_PENDING   = 4'h2;
	localparam logic [CODE_W-1:0] ACK_BUSY      = 4'h4;
	localparam logic [CODE_W-1:0] ACK_DATA_ERR  = 4'hD;
	localparam logic [CODE_W-1:0] RESP_COMPLETE = 4'h0;
	localparam logic [CODE_W-1:0] RESP_DATA_ERR = 4'h5;

	// =====================================================
	// Receive context modes
	localparam logic [MODE_W-1:0] MODE_ASYNC = 2'h0;
	localparam logic [MODE_W-1:0] MODE_PPB   = 2'h1;
	localparam logic [MODE_W-1:0] MODE_BFILL = 2'h2;

	// =====================================================
	// Reset values
	localparam logic [WORD_W-1:0] PTR_RST = 32'h0000_0000;
	localparam logic [WORD_W-1:0] RPT_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		PR_IDLE = 3'b001,
		PR_SEND = 3'b010,
		PR_ACK  = 3'b100
	} hbe_pr_state_e;
endpackage

// ==== design/hbe_fifo.sv ====
`timescale 1ns/10ps
module hbe_fifo #(
	parameter int unsigned DEPTH = 3,
	parameter int unsigned WIDTH = 64,
	localparam int unsigned CW = $clog2(DEPTH + 1),
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
)(
	input  logic             sys_clk,
	input  logic             reset,
	input  logic             push,
	input  logic [WIDTH-1:0] push_data,
	input  logic             pop,
	output logic [WIDTH-1:0] head,
	output logic [CW-1:0]    count,
	output logic             empty,
	output logic             full
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [CW-1:0]               cnt;
	} hbe_fifo_s;

	hbe_fifo_s st_r;
	hbe_fifo_s st_nxt;
	logic      do_push;
	logic      do_pop;

	assign empty   = (st_r.cnt == '0);
	assign full    = (st_r.cnt == CW'(DEPTH));
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign head    = st_r.mem[st_r.rp];
	assign count   = st_r.cnt;

	always_comb
	begin
		st_nxt = st_r;
		if (do_push)
		begin
			st_nxt.mem[st_r.wp] = push_data;
			st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
		end
		if (do_pop)
			st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
		st_nxt.cnt = st_r.cnt + CW'(do_push) - CW'(do_pop);
	end

	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
			st_r <= '0;
		else
			st_r <= st_nxt;

	property p_fifo_bound;
		@(posedge sys_clk) disable iff (reset)
		full && push && !pop |=> $stable(st_r.cnt) && st_r.cnt == CW'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overfilled");
endmodule

// ==== design/hbe_rxerr.sv ====
`timescale 1ns/10ps
module hbe_rxerr
	import hbe_pkg::*;
(
	input  logic                       sys_clk,
	input  logic                       reset,
	input  logic [hbe_pkg::MODE_W-1:0] mode,
	input  logic                       host_err,
	input  logic                       overrun,
	input  logic                       pkt_end,
	input  logic                       xfer_done,
	input  logic                       desc_irq,
	input  logic                       resume,
	input  logic [hbe_pkg::WORD_W-1:0] current_desc_addr,
	output logic                       halted,
	output logic [hbe_pkg::EVT_W-1:0]  event_code,
	output logic [hbe_pkg::WORD_W-1:0] desc_ptr,
	output logic                       flush_all,
	output logic                       discard_pkt,
	output logic                       backout,
	output logic                       status_upd,
	output logic                       fatal,
	output logic                       ctx_irq
);
	typedef struct packed {
		logic              halted;
		logic [EVT_W-1:0]  evt;
		logic [WORD_W-1:0] ptr;
		logic              flush;
		logic              discard;
		logic              backout;
		logic              status;
		logic              fatal;
		logic              irq;
	} hbe_rx_s;

	hbe_rx_s st_r;
	hbe_rx_s st_nxt;
	logic    live;

	// Error in the same cycle as a restart still counts
	assign live = !st_r.halted || resume;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.backout = 1'b0;
		st_nxt.status = 1'b0;
		st_nxt.fatal = 1'b0;
		st_nxt.irq = 1'b0;
		if (resume)
		begin
			st_nxt.halted = 1'b0;
			st_nxt.flush = 1'b0;
			st_nxt.evt = EVT_NONE;
		end
		if (pkt_end)
			st_nxt.discard = 1'b0;
		if (!st_r.halted)
			st_nxt.ptr = current_desc_addr;
		if (live && host_err && mode == MODE_PPB)
		begin
			st_nxt.evt = EVT_DATA_WRITE;
			st_nxt.status = 1'b1;
			st_nxt.discard = 1'b1;
		end
		else if (live && host_err)
		begin
			st_nxt.halted = 1'b1;
			st_nxt.evt = EVT_DATA_WRITE;
			st_nxt.fatal = 1'b1;
			st_nxt.ptr = current_desc_addr;
			st_nxt.flush = 1'b1;
		end
		else if (live && overrun && mode == MODE_PPB)
		begin
			st_nxt.evt = EVT_OVERRUN;
			st_nxt.status = 1'b1;
			st_nxt.discard = 1'b1;
		end
		else if (live && overrun && mode == MODE_BFILL)
		begin
			st_nxt.backout = 1'b1;
			st_nxt.discard = 1'b1;
		end
		else if (live && xfer_done && desc_irq)
			st_nxt.irq = 1'b1;
	end

	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
			st_r <= '{halted: 1'b0, evt: EVT_NONE, ptr: PTR_RST, default: 1'b0};
		else
			st_r <= st_nxt;

	assign halted      = st_r.halted;
	assign event_code  = st_r.evt;
	assign desc_ptr    = st_r.ptr;
	assign flush_all   = st_r.flush;
	assign discard_pkt = st_r.discard;
	assign backout     = st_r.backout;
	assign status_upd  = st_r.status;
	assign fatal       = st_r.fatal;
	assign ctx_irq     = st_r.irq;

	property p_rx_halt;
		@(posedge sys_clk) disable iff (reset)
		!halted && host_err && mode != MODE_PPB
		|=> halted && fatal && !ctx_irq && event_code == EVT_DATA_WRITE && flush_all;
	endproperty
	a_rx_halt: assert property (p_rx_halt) else $error("rx error did not halt");

	property p_rx_ptr_hold;
		@(posedge sys_clk) disable iff (reset)
		halted && !resume |=> $stable(desc_ptr);
	endproperty
	a_rx_ptr_hold: assert property (p_rx_ptr_hold) else $error("pointer moved");

	property p_rx_backout;
		@(posedge sys_clk) disable iff (reset)
		!halted && overrun && !host_err && mode == MODE_BFILL
		|=> backout && !status_upd && discard_pkt;
	endproperty
	a_rx_backout: assert property (p_rx_backout) else $error("overrun not backed out");
endmodule

// ==== verif/hbe_mem.sv ====
`timescale 1ns/10ps
// =====================================================
// Host memory seen by posted writes
module hbe_mem (
	input  logic       sys_clk,
	input  logic       reset,
	input  logic       issue,
	input  logic       fail_sel,
	input  logic [3:0] lat,
	output logic       wr_done,
	output logic       wr_fail
);
	logic [3:0] pend_r;
	logic [3:0] wait_r;
	logic       ans;
	// Oldest write answered first, one every lat+1 cycles, so writes pile up
	assign ans = (pend_r != 4'h0) && (wait_r == 4'h0);
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pend_r  <= 4'h0;
			wait_r  <= 4'h0;
			wr_done <= 1'b0;
			wr_fail <= 1'b0;
		end
		else
		begin
			wr_done <= ans & ~fail_sel;
			wr_fail <= ans & fail_sel;
			pend_r  <= pend_r + {3'h0, issue} - {3'h0, ans};
			wait_r  <= (ans || pend_r == 4'h0) ? lat : wait_r - 4'h1;
		end
	end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	import hbe_pkg::*;
	localparam int unsigned DEPTH = 3;
	logic sys_clk, reset, it_store_req, it_store_done, it_store_err, it_pkt_ready;
	logic it_fifo_load, it_abort, fatal_error_flag, pr_start, pr_rd_err, pr_underrun;
	logic pr_word_sent, pr_pkt_end, pr_ack_valid, pr_stop, pr_retry, pr_busy, pw_enable;
	logic pw_req, pw_wr_done, pw_wr_fail, pw_flag_clr, pw_ack_valid, pw_drop_pkt;
	logic posted_fail_flag, fail_sel;
	logic [EVT_W-1:0] it_event_code;
	logic [MODE_W-1:0] ir_mode;
	logic [RX_N-1:0] rx_host_err, rx_overrun, rx_pkt_end, rx_xfer_done, rx_desc_irq;
	logic [RX_N-1:0] rx_resume, context_halted_flag, rx_flush_all, rx_discard_pkt;
	logic [RX_N-1:0] rx_backout, rx_status_upd, rx_ctx_irq;
	logic [RX_N-1:0][WORD_W-1:0] current_desc_addr, descriptor_list_pointer;
	logic [RX_N-1:0][EVT_W-1:0] context_event_code;
	logic [CODE_W-1:0] pr_ack_code, pr_resp_code, pw_ack_code;
	logic [3:0] pr_max_retries, lat;
	logic [SRC_W-1:0] requester_node_ident, k;
	logic [OFF_W-1:0] pw_dest_offset;
	logic [WORD_W-1:0] posted_fail_source_and_offset_upper, posted_fail_offset_lower;
	int err_count, n_checks, drops, i, j;

	hbe_unit #(.PW_DEPTH(DEPTH), .PW_SUPPORT(1'b1)) i_dut (.*);
	hbe_mem i_mem (.sys_clk(sys_clk), .reset(reset), .fail_sel(fail_sel), .lat(lat),
		.issue(pw_ack_valid & (pw_ack_code == ACK_COMPLETE)),
		.wr_done(pw_wr_done), .wr_fail(pw_wr_fail));

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (pw_drop_pkt === 1'b1)
			drops++;

	// =====================================================
	// Tasks
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_end(input string s);
		$display("test %s ends, mismatches so far %0d", s, err_count);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic pw_write(input logic [CODE_W-1:0] exp);
		@(posedge sys_clk);
		pw_req <= 1'b1;
		requester_node_ident <= 16'h0A10 + k;
		pw_dest_offset <= {16'h00C0 + k, 16'h8000, k};
		@(posedge sys_clk);
		pw_req <= 1'b0;
		@(negedge sys_clk);
		for (i = 0; i < 4 && pw_ack_valid !== 1'b1; i++) @(negedge sys_clk);
		chk(pw_ack_code, exp);
	endtask
	// Word flag puts one word out first; und picks an underrun over a host read error
	task automatic pr_go(input logic word, input logic und);
		@(posedge sys_clk);
		pr_start <= 1'b1;
		@(posedge sys_clk);
		pr_start <= 1'b0;
		pr_word_sent <= word;
		@(posedge sys_clk);
		pr_word_sent <= 1'b0;
		pr_rd_err <= !und;
		pr_underrun <= und;
		@(posedge sys_clk);
		pr_rd_err <= 1'b0;
		pr_underrun <= 1'b0;
		@(negedge sys_clk);
		for (i = 0; i < 4 && pr_stop !== 1'b1; i++) @(negedge sys_clk);
		chk(pr_stop, 1'b1);
	endtask
	task automatic pr_ack(input logic [CODE_W-1:0] code);
		@(posedge sys_clk);
		pr_pkt_end <= 1'b1;
		@(posedge sys_clk);
		pr_pkt_end <= 1'b0;
		pr_ack_valid <= 1'b1;
		pr_ack_code <= code;
		@(posedge sys_clk);
		pr_ack_valid <= 1'b0;
		@(negedge sys_clk);
		for (i = 0; i < 4 && pr_retry !== 1'b1; i++) @(negedge sys_clk);
	endtask

	// =====================================================
	// Sequence
	initial
	begin
		{it_store_req, it_store_done, it_store_err, it_pkt_ready, pr_start, pr_rd_err} = '0;
		{pr_underrun, pr_word_sent, pr_pkt_end, pr_ack_valid, pw_req, pw_flag_clr} = '0;
		{rx_host_err, rx_overrun, rx_pkt_end, rx_xfer_done, rx_resume, pr_ack_code} = '0;
		{requester_node_ident, pw_dest_offset, sys_clk, k} = '0;
		{reset, pw_enable, fail_sel, rx_desc_irq} = '1;
		lat = 4'hF;
		pr_max_retries = 4'h4;
		ir_mode = MODE_BFILL;
		current_desc_addr = {2{32'h0000_1230}};
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		chk(pw_ack_code, ACK_PENDING);
		chk(posted_fail_flag, 1'b0);
		test_end("reset");
		for (k = 0; k <= DEPTH; k++) pw_write((k < DEPTH) ? ACK_COMPLETE : ACK_PENDING);
		for (k = 0; k < DEPTH; k++)
		begin
			for (i = 0; i < 80 && posted_fail_flag !== 1'b1; i++) @(negedge sys_clk);
			chk(posted_fail_source_and_offset_upper, {16'h0A10 + k, 16'h00C0 + k});
			chk(posted_fail_offset_lower, {16'h8000, k});
			@(posedge sys_clk);
			pw_flag_clr <= 1'b1;
			@(posedge sys_clk);
			pw_flag_clr <= 1'b0;
			@(negedge sys_clk) chk(posted_fail_flag, 1'b0);
		end
		repeat (20) @(negedge sys_clk);
		chk(posted_fail_flag, 1'b0);
		chk(drops, DEPTH);
		fail_sel <= 1'b0;
		pw_write(ACK_COMPLETE);
		pw_enable <= 1'b0;
		pw_write(ACK_PENDING);
		test_end("posted");
		for (j = 0; j < 3; j++)
		begin
			pr_go(j != 0, j == 2);
			chk(pr_resp_code, j ? RESP_COMPLETE : RESP_DATA_ERR);
			pr_ack(j ? ACK_DATA_ERR : ACK_BUSY);
			chk(pr_retry, 1'b1);
			chk(pr_resp_code, (j == 2) ? RESP_COMPLETE : RESP_DATA_ERR);
			chk({pr_stop, pr_busy}, {j != 2, 1'b1});
			pr_ack(ACK_COMPLETE);
		end
		chk(pr_busy, 1'b0);
		test_end("physical read");
		@(posedge sys_clk);
		it_pkt_ready <= 1'b1;
		it_store_req <= 1'b1;
		@(posedge sys_clk);
		it_store_req <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(it_fifo_load, 1'b0);
		@(posedge sys_clk);
		it_store_err <= 1'b1;
		@(posedge sys_clk);
		it_store_err <= 1'b0;
		@(negedge sys_clk) chk(it_abort, 1'b1);
		chk(it_fifo_load, 1'b1);
		chk(it_event_code, EVT_DATA_WRITE);
		test_end("store value");
		for (j = 0; j < RX_N; j++)
		begin
			@(posedge sys_clk);
			rx_host_err[j] <= 1'b1;
			rx_xfer_done[j] <= 1'b1;
			@(posedge sys_clk);
			rx_host_err <= '0;
			rx_xfer_done <= '0;
			current_desc_addr[j] <= 32'h0000_5670;
			@(negedge sys_clk) chk(fatal_error_flag, 1'b1);
			chk(rx_ctx_irq[j], 1'b0);
			chk(context_event_code[j], EVT_DATA_WRITE);
			repeat (2) @(negedge sys_clk);
			chk(descriptor_list_pointer[j], 32'h0000_1230);
			chk({context_halted_flag[j], rx_flush_all[j]}, 2'b11);
			@(posedge sys_clk);
			rx_resume[j] <= 1'b1;
			@(posedge sys_clk);
			rx_resume <= '0;
		end
		ir_mode <= MODE_PPB;
		for (j = 0; j < 3; j++)
		begin
			@(posedge sys_clk);
			rx_host_err <= {j == 0, 1'b0};
			rx_overrun <= {j != 0, 1'b0};
			@(posedge sys_clk);
			rx_host_err <= 2'b00;
			rx_overrun <= 2'b00;
			@(negedge sys_clk);
			chk(context_event_code[1], j ? EVT_OVERRUN : EVT_DATA_WRITE);
			chk({rx_discard_pkt[1], rx_backout[1]}, {1'b1, j == 2});
			chk({rx_status_upd[1], context_halted_flag[1]}, {j != 2, 1'b0});
			@(posedge sys_clk);
			rx_pkt_end <= 2'b10;
			ir_mode <= (j == 0) ? MODE_PPB : MODE_BFILL;
			@(posedge sys_clk);
			rx_pkt_end <= 2'b00;
		end
		test_end("receive");
		tally_and_finish();
	end

	// Longest path is a few hundred cycles; cut a hang well beyond that
	initial
	begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule
